// File: hw/pcc_defines.svh
// Constants of the PLL and core clock control block.
`ifndef PCC_DEFINES_SVH
`define PCC_DEFINES_SVH

`define PCC_ADDR_KEY        8'hc1
`define PCC_ADDR_POWER      8'hc5
`define PCC_ADDR_MEAS_START 8'hd8
`define PCC_KEY_POWER       8'ha7
`define PCC_KEY_RTC         8'hea
`define PCC_KEY_RESET       8'h00
`define PCC_POWER_RESET     8'h82
`define PCC_POWER_WMASK     8'h77
`define PCC_POWER_SET       8'h80
`define PCC_BIT_METER_SHUT  6
`define PCC_BIT_CORE_OFF    4
`define PCC_BIT_ACK         7
`define PCC_DIV_MSB         2

`define PCC_MCLK_HZ         64'd125000000
`define PCC_PLL_HZ          64'd4096000
`define PCC_XTAL_HZ         64'd32768
`define PCC_METER_HZ        64'd819200
`define PCC_NCO_INC         24'(((`PCC_PLL_HZ * 64'd2) << 24) / `PCC_MCLK_HZ)
`define PCC_HALF_PER_XTAL   9'((`PCC_PLL_HZ * 64'd2) / `PCC_XTAL_HZ)
`define PCC_METER_HALF      3'(`PCC_PLL_HZ / `PCC_METER_HZ)
`define PCC_LOCK_TOL        9'h002
`define PCC_LOCK_GOOD       3'h4
`define PCC_RESET_PULSE     5'h10

`endif

// File: hw/pcc_pkg.sv
// Types shared by the clock control modules.
package pcc_pkg;
    typedef logic [7:0] pcc_byte_t;
    typedef logic [2:0] pcc_div_t;
    typedef enum logic [0:0] {
        LK_ACQUIRE = 1'b0,
        LK_LOCKED  = 1'b1
    } pcc_lock_state_t;
endpackage : pcc_pkg

// File: hw/pcc_clk_if.sv
// PLL tick and lock status passed from the lock loop to its users.
`timescale 1ns/1ps
`default_nettype none
interface pcc_clk_if;
    logic pll_tick;
    logic locked;
    logic lock_lost;
    modport src (output pll_tick, output locked, output lock_lost);
    modport snk (input pll_tick, input locked, input lock_lost);
endinterface : pcc_clk_if
`default_nettype wire

// File: hw/pcc_pll_lock.sv
// Digital PLL that tracks the crystal and reports lock.
`timescale 1ns/1ps
`default_nettype none
`include "pcc_defines.svh"
module pcc_pll_lock (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic xtal_in,
    pcc_clk_if.src    clk_o
);
    import pcc_pkg::*;

    logic [23:0]     nco_reg, nco_next, inc_reg, inc_next;
    logic            tick_reg, tick_next;
    logic [2:0]      xs_reg, xs_next;
    logic            xlvl_reg, xlvl_next;
    logic [8:0]      cnt_reg, cnt_next;
    logic [2:0]      good_reg, good_next;
    logic            lost_reg, lost_next;
    pcc_lock_state_t state_reg, state_next;
    logic            rise, in_win, late;
    logic [24:0]     sum;

    always_comb begin
        sum = {1'b0, nco_reg} + {1'b0, inc_reg};
        nco_next = sum[23:0];
        tick_next = sum[24];
        xs_next = {xs_reg[1:0], xtal_in};
        xlvl_next = (xs_reg[1] == xs_reg[2]) ? xs_reg[2] : xlvl_reg;
        rise = (xs_reg[1] == xs_reg[2]) && xs_reg[2] && !xlvl_reg;
        in_win = (cnt_reg >= `PCC_HALF_PER_XTAL - `PCC_LOCK_TOL)
              && (cnt_reg <= `PCC_HALF_PER_XTAL + `PCC_LOCK_TOL);
        late = cnt_reg > `PCC_HALF_PER_XTAL + `PCC_LOCK_TOL;
        cnt_next = cnt_reg;
        if (rise) begin
            cnt_next = 9'h000;
        end else if (tick_reg && cnt_reg != 9'h1ff) begin
            cnt_next = cnt_reg + 9'h001;
        end
        // The increment is trimmed once per crystal period toward the nominal count.
        inc_next = inc_reg;
        if (rise && cnt_reg < `PCC_HALF_PER_XTAL) begin
            inc_next = inc_reg + 24'h000001;
        end else if (rise && cnt_reg > `PCC_HALF_PER_XTAL) begin
            inc_next = inc_reg - 24'h000001;
        end
        state_next = state_reg;
        good_next = good_reg;
        lost_next = 1'b0;
        unique case (state_reg)
            LK_ACQUIRE: begin
                if (rise) begin
                    good_next = in_win ? good_reg + 3'h1 : 3'h0;
                    if (in_win && good_reg == `PCC_LOCK_GOOD - 3'h1) begin
                        state_next = LK_LOCKED;
                        good_next = 3'h0;
                    end
                end
            end
            LK_LOCKED: begin
                if ((rise && !in_win) || late) begin
                    state_next = LK_ACQUIRE;
                    lost_next = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            nco_reg <= 24'h000000;
            inc_reg <= `PCC_NCO_INC;
            tick_reg <= 1'b0;
            xs_reg <= 3'h0;
            xlvl_reg <= 1'b0;
            cnt_reg <= 9'h000;
            good_reg <= 3'h0;
            lost_reg <= 1'b0;
            state_reg <= LK_ACQUIRE;
        end else begin
            nco_reg <= nco_next;
            inc_reg <= inc_next;
            tick_reg <= tick_next;
            xs_reg <= xs_next;
            xlvl_reg <= xlvl_next;
            cnt_reg <= cnt_next;
            good_reg <= good_next;
            lost_reg <= lost_next;
            state_reg <= state_next;
        end
    end

    assign clk_o.pll_tick = tick_reg;
    assign clk_o.locked = (state_reg == LK_LOCKED);
    assign clk_o.lock_lost = lost_reg;

    lock_lost_src_a: assert property (@(posedge mclk) disable iff (!rst_b)
        lost_reg |-> state_reg == LK_ACQUIRE && $past(state_reg) == LK_LOCKED)
        else $error("lock loss reported without prior lock");
    lock_timeout_a: assert property (@(posedge mclk) disable iff (!rst_b)
        state_reg == LK_LOCKED && late |=> lost_reg)
        else $error("missing crystal edge did not drop lock");
endmodule : pcc_pll_lock
`default_nettype wire

// File: hw/pcc_clk_div.sv
// Core and metering clock dividers driven by the PLL tick.
`timescale 1ns/1ps
`default_nettype none
`include "pcc_defines.svh"
module pcc_clk_div (
    input  wire logic         mclk,
    input  wire logic         rst_b,
    pcc_clk_if.snk            clk_i,
    input  wire pcc_pkg::pcc_div_t div_sel,
    input  wire logic         meter_stop,
    output logic              pll_clk,
    output logic              core_clk,
    output logic              meter_clk
);
    import pcc_pkg::*;

    logic [6:0] div_reg, div_next, mask;
    logic [2:0] mcnt_reg, mcnt_next;
    logic       pll_next, core_next, meter_next;

    always_comb begin
        mask = 7'((8'h01 << div_sel) - 8'h01);
        div_next = clk_i.pll_tick ? div_reg + 7'h01 : div_reg;
        pll_next = clk_i.pll_tick ? !pll_clk : pll_clk;
        core_next = core_clk;
        if (clk_i.pll_tick && (div_reg & mask) == mask) begin
            core_next = !core_clk;
        end
        mcnt_next = mcnt_reg;
        meter_next = meter_clk;
        if (meter_stop) begin
            mcnt_next = 3'h0;
            meter_next = 1'b0;
        end else if (clk_i.pll_tick) begin
            // Counts PLL half periods only, so the divider setting never reaches it.
            mcnt_next = (mcnt_reg == `PCC_METER_HALF - 3'h1) ? 3'h0 : mcnt_reg + 3'h1;
            meter_next = (mcnt_reg == `PCC_METER_HALF - 3'h1) ? !meter_clk : meter_clk;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_reg <= 7'h00;
            mcnt_reg <= 3'h0;
            pll_clk <= 1'b0;
            core_clk <= 1'b0;
            meter_clk <= 1'b0;
        end else begin
            div_reg <= div_next;
            mcnt_reg <= mcnt_next;
            pll_clk <= pll_next;
            core_clk <= core_next;
            meter_clk <= meter_next;
        end
    end

    meter_stop_a: assert property (@(posedge mclk) disable iff (!rst_b)
        meter_stop |=> !meter_clk && mcnt_reg == 3'h0)
        else $error("metering clock runs while shut down");
    core_full_a: assert property (@(posedge mclk) disable iff (!rst_b)
        div_sel == 3'h0 && clk_i.pll_tick |=> core_clk != $past(core_clk))
        else $error("core clock missed a toggle at full rate");
endmodule : pcc_clk_div
`default_nettype wire

// File: hw/pcc_top.sv
// PLL clock control: key and power control registers, lock fault handling.
`timescale 1ns/1ps
`default_nettype none
`include "pcc_defines.svh"
module pcc_top (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              xtal_in,
    input  wire pcc_pkg::pcc_byte_t sfr_addr,
    input  wire pcc_pkg::pcc_byte_t sfr_wdata,
    input  wire logic              sfr_wr,
    input  wire logic              sfr_rd,
    output pcc_pkg::pcc_byte_t     sfr_rdata,
    input  wire logic              rtc_protected_wr_done,
    input  wire logic              power_saving_mode_one,
    output logic                   pll_clk,
    output logic                   core_clk,
    output logic                   meter_clk,
    output logic                   pll_locked,
    output logic                   core_reset,
    output logic                   lock_loss_fault_flag,
    output logic                   metering_shutdown,
    output logic                   processor_shutdown,
    output logic                   rtc_write_unlock
);
    import pcc_pkg::*;

    logic      rst_s1_reg, rst_sync_b;
    pcc_byte_t unlock_key_reg, unlock_key_next;
    pcc_byte_t power_clock_control_reg, power_clock_control_next;
    logic      armed_reg, armed_next;
    pcc_byte_t rdata_next;
    logic      fault_next;
    logic [4:0] rst_cnt_reg, rst_cnt_next;
    logic      core_reset_next, locked_next;
    logic      meter_stop_next, proc_off_next, rtc_unlock_next;
    logic      wr_key, wr_power, power_ok, ack_wr;

    pcc_clk_if clk_bus ();

    // The reset enters asynchronously but is released on the clock.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_reg <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_sync_b <= rst_s1_reg;
        end
    end

    pcc_pll_lock u_lock (
        .mclk    (mclk),
        .rst_b   (rst_sync_b),
        .xtal_in (xtal_in),
        .clk_o   (clk_bus.src)
    );

    pcc_clk_div u_div (
        .mclk      (mclk),
        .rst_b     (rst_sync_b),
        .clk_i     (clk_bus.snk),
        .div_sel   (power_clock_control_reg[`PCC_DIV_MSB:0]),
        .meter_stop(power_clock_control_reg[`PCC_BIT_METER_SHUT]),
        .pll_clk   (pll_clk),
        .core_clk  (core_clk),
        .meter_clk (meter_clk)
    );

    // Register writes and key handling.
    always_comb begin
        wr_key = sfr_wr && sfr_addr == `PCC_ADDR_KEY;
        wr_power = sfr_wr && sfr_addr == `PCC_ADDR_POWER;
        power_ok = wr_power && armed_reg && unlock_key_reg == `PCC_KEY_POWER;
        ack_wr = sfr_wr && sfr_addr == `PCC_ADDR_MEAS_START && sfr_wdata[`PCC_BIT_ACK];

        unlock_key_next = unlock_key_reg;
        if (rtc_protected_wr_done || power_ok) begin
            unlock_key_next = `PCC_KEY_RESET;
        end else if (wr_key) begin
            unlock_key_next = sfr_wdata;
        end

        // Any write other than the power key disarms the power register.
        armed_next = armed_reg;
        if (sfr_wr) begin
            armed_next = wr_key && sfr_wdata == `PCC_KEY_POWER;
        end

        power_clock_control_next = power_clock_control_reg;
        if (power_ok) begin
            power_clock_control_next = (sfr_wdata & `PCC_POWER_WMASK) | `PCC_POWER_SET;
        end

        rtc_unlock_next = unlock_key_next == `PCC_KEY_RTC;
        meter_stop_next = power_clock_control_next[`PCC_BIT_METER_SHUT];
        proc_off_next = power_clock_control_reg[`PCC_BIT_CORE_OFF] && power_saving_mode_one;
    end

    // Read data, lock fault and the core reset pulse.
    always_comb begin
        rdata_next = sfr_rdata;
        if (sfr_rd) begin
            unique case (sfr_addr)
                `PCC_ADDR_KEY:   rdata_next = unlock_key_reg;
                `PCC_ADDR_POWER: rdata_next = power_clock_control_reg;
                default:         rdata_next = 8'h00;
            endcase
        end

        // A lock loss in the same cycle as the acknowledge keeps the flag set.
        fault_next = clk_bus.lock_lost || (lock_loss_fault_flag && !ack_wr);

        rst_cnt_next = rst_cnt_reg;
        if (clk_bus.lock_lost) begin
            rst_cnt_next = `PCC_RESET_PULSE;
        end else if (rst_cnt_reg != 5'h00) begin
            rst_cnt_next = rst_cnt_reg - 5'h01;
        end
        core_reset_next = rst_cnt_next != 5'h00;
        locked_next = clk_bus.locked;
    end

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            unlock_key_reg <= `PCC_KEY_RESET;
            power_clock_control_reg <= `PCC_POWER_RESET;
            armed_reg <= 1'b0;
            sfr_rdata <= 8'h00;
            lock_loss_fault_flag <= 1'b0;
            rst_cnt_reg <= 5'h00;
            core_reset <= 1'b0;
            pll_locked <= 1'b0;
            metering_shutdown <= 1'b0;
            processor_shutdown <= 1'b0;
            rtc_write_unlock <= 1'b0;
        end else begin
            unlock_key_reg <= unlock_key_next;
            power_clock_control_reg <= power_clock_control_next;
            armed_reg <= armed_next;
            sfr_rdata <= rdata_next;
            lock_loss_fault_flag <= fault_next;
            rst_cnt_reg <= rst_cnt_next;
            core_reset <= core_reset_next;
            pll_locked <= locked_next;
            metering_shutdown <= meter_stop_next;
            processor_shutdown <= proc_off_next;
            rtc_write_unlock <= rtc_unlock_next;
        end
    end

    key_rtc_clear_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        rtc_protected_wr_done |=> unlock_key_reg == `PCC_KEY_RESET && !rtc_write_unlock)
        else $error("key not cleared after protected timekeeping write");
    power_locked_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        wr_power && !armed_reg |=> $stable(power_clock_control_reg))
        else $error("power control changed without key");
    power_update_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        wr_key && sfr_wdata == `PCC_KEY_POWER ##1 wr_power
        |=> power_clock_control_reg == (($past(sfr_wdata) & `PCC_POWER_WMASK) | `PCC_POWER_SET)
            && unlock_key_reg == `PCC_KEY_RESET)
        else $error("keyed power control write not taken");
    fault_set_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        clk_bus.lock_lost |=> lock_loss_fault_flag && core_reset)
        else $error("lock loss did not set fault and reset");
    fault_clear_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        ack_wr && !clk_bus.lock_lost |=> !lock_loss_fault_flag)
        else $error("acknowledge did not clear fault");
    core_reset_len_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        clk_bus.lock_lost |=> core_reset [*8])
        else $error("core reset pulse too short");
    rtc_unlock_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        wr_key && !rtc_protected_wr_done |=> rtc_write_unlock == ($past(sfr_wdata) == `PCC_KEY_RTC))
        else $error("timekeeping unlock does not follow key");
    proc_shut_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
        power_clock_control_reg[`PCC_BIT_CORE_OFF] && power_saving_mode_one |=> processor_shutdown)
        else $error("core not shut down in power saving mode");
endmodule : pcc_top
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking testbench for the PLL clock control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pcc_pkg::*;

    typedef struct {
        int        kind;
        pcc_byte_t v;
    } pcc_tb_note_t;

    logic         mclk;
    logic         rst_b;
    logic         xtal_in;
    logic         xtal_run;
    int           xtal_cnt;
    pcc_byte_t    sfr_addr;
    pcc_byte_t    sfr_wdata;
    pcc_byte_t    sfr_rdata;
    pcc_byte_t    meas;
    pcc_byte_t    d;
    logic         sfr_wr;
    logic         sfr_rd;
    logic         rtc_protected_wr_done;
    logic         power_saving_mode_one;
    logic         pll_clk;
    logic         core_clk;
    logic         meter_clk;
    logic         pll_locked;
    logic         core_reset;
    logic         lock_loss_fault_flag;
    logic         metering_shutdown;
    logic         processor_shutdown;
    logic         rtc_write_unlock;
    logic         snap;
    logic         rd_q;
    logic [31:0]  rng;
    pcc_byte_t    status;
    pcc_tb_note_t notes[$];
    pcc_tb_note_t mon_note;
    int           miscompares;
    int           cmp_count;

    assign status = {3'b000, rtc_write_unlock, processor_shutdown, metering_shutdown,
                     lock_loss_fault_flag, core_reset};

    pcc_top i_dut (
        .mclk                  (mclk),
        .rst_b                 (rst_b),
        .xtal_in               (xtal_in),
        .sfr_addr              (sfr_addr),
        .sfr_wdata             (sfr_wdata),
        .sfr_wr                (sfr_wr),
        .sfr_rd                (sfr_rd),
        .sfr_rdata             (sfr_rdata),
        .rtc_protected_wr_done (rtc_protected_wr_done),
        .power_saving_mode_one (power_saving_mode_one),
        .pll_clk               (pll_clk),
        .core_clk              (core_clk),
        .meter_clk             (meter_clk),
        .pll_locked            (pll_locked),
        .core_reset            (core_reset),
        .lock_loss_fault_flag  (lock_loss_fault_flag),
        .metering_shutdown     (metering_shutdown),
        .processor_shutdown    (processor_shutdown),
        .rtc_write_unlock      (rtc_write_unlock)
    );

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Crystal half period of 1907 mclk cycles, close to 32.768 kHz; it stops when xtal_run is low.
    always @(posedge mclk) begin
        if (xtal_run) begin
            if (xtal_cnt == 1906) begin
                xtal_cnt <= 0;
                xtal_in  <= ~xtal_in;
            end else begin
                xtal_cnt <= xtal_cnt + 1;
            end
        end
    end

    task automatic chk(input pcc_byte_t seen, input pcc_byte_t exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Kind 0 is read data, 1 the status outputs, 2 a value measured by the bench.
    always @(posedge mclk) begin
        rd_q <= sfr_rd;
        if (rd_q || snap) begin
            if (notes.size() == 0) begin
                miscompares++;
                $display("BAD t=%0t seen=%h exp=%h", $time, sfr_rdata, 8'h00);
            end else begin
                mon_note = notes.pop_front();
                chk(mon_note.kind == 0 ? sfr_rdata : (mon_note.kind == 1 ? status : meas), mon_note.v);
            end
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xs

    task automatic close_out;
        $display("Counts: compares=%0d mismatches=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic sfr_write(input pcc_byte_t a, input pcc_byte_t dat);
        @(posedge mclk);
        sfr_addr  <= a;
        sfr_wdata <= dat;
        sfr_wr    <= 1'b1;
        @(posedge mclk);
        sfr_wr    <= 1'b0;
    endtask : sfr_write

    task automatic sfr_read(input pcc_byte_t a, input pcc_byte_t e);
        notes.push_back('{0, e});
        @(posedge mclk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge mclk);
        sfr_rd   <= 1'b0;
    endtask : sfr_read

    task automatic expect_snap(input int kind, input pcc_byte_t e);
        notes.push_back('{kind, e});
        @(posedge mclk);
        snap <= 1'b1;
        @(posedge mclk);
        snap <= 1'b0;
    endtask : expect_snap

    // Key and power control write on consecutive edges, the strobe held high between them.
    task automatic pow_write(input pcc_byte_t dat);
        @(posedge mclk);
        sfr_addr  <= 8'hc1;
        sfr_wdata <= 8'ha7;
        sfr_wr    <= 1'b1;
        @(posedge mclk);
        sfr_addr  <= 8'hc5;
        sfr_wdata <= dat;
        @(posedge mclk);
        sfr_wr    <= 1'b0;
    endtask : pow_write

    // Counts PLL clock rises over one period of the core (sel 0) or metering (sel 1) clock.
    task automatic ratio(input int sel, input int lim);
        int   i;
        int   rises;
        logic sp;
        logic pp;
        // Two edges let a new divider setting take over before the first rise is taken.
        repeat (2) @(posedge mclk);
        meas  = 8'h00;
        rises = 0;
        sp    = sel ? meter_clk : core_clk;
        pp    = pll_clk;
        for (i = 0; i < lim && rises < 2; i++) begin
            @(posedge mclk);
            if (rises == 1 && pll_clk && !pp) meas++;
            if ((sel ? meter_clk : core_clk) && !sp) rises++;
            sp = sel ? meter_clk : core_clk;
            pp = pll_clk;
        end
    endtask : ratio

    initial begin
        repeat (95000) @(posedge mclk);
        miscompares++;
        close_out();
    end

    initial begin
        int i;
        int n;
        rst_b = 1'b0;
        xtal_in = 1'b0;
        xtal_run = 1'b1;
        xtal_cnt = 0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        rtc_protected_wr_done = 1'b0;
        power_saving_mode_one = 1'b0;
        snap = 1'b0;
        rd_q = 1'b0;
        meas = 8'h00;
        rng = 32'd11;
        miscompares = 0;
        cmp_count = 0;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        sfr_read(8'hc5, 8'h82);
        sfr_read(8'hc1, 8'h00);
        sfr_read(8'h3a, 8'h00);
        expect_snap(1, 8'h00);
        sfr_write(8'hc5, 8'h00);
        sfr_read(8'hc5, 8'h82);
        sfr_write(8'hc1, 8'ha7);
        sfr_write(8'hd8, 8'h00);
        sfr_write(8'hc5, 8'h00);
        sfr_read(8'hc5, 8'h82);
        sfr_write(8'hc1, 8'hea);
        expect_snap(1, 8'h10);
        sfr_write(8'hc5, 8'h00);
        sfr_read(8'hc5, 8'h82);
        sfr_write(8'hc1, 8'hea);
        @(posedge mclk);
        rtc_protected_wr_done <= 1'b1;
        @(posedge mclk);
        rtc_protected_wr_done <= 1'b0;
        sfr_read(8'hc1, 8'h00);
        expect_snap(1, 8'h00);
        for (i = 0; i < 6; i++) begin
            rng = xs(rng);
            d = rng[7:0] & 8'hd7;
            @(posedge mclk);
            power_saving_mode_one <= rng[8];
            pow_write(d);
            sfr_read(8'hc5, (d & 8'h77) | 8'h80);
            sfr_read(8'hc1, 8'h00);
            expect_snap(1, {4'h0, d[4] & rng[8], d[6], 2'b00});
        end
        // Key and power write with an idle edge between them, core shutdown in mode one.
        @(posedge mclk);
        power_saving_mode_one <= 1'b1;
        sfr_write(8'hc1, 8'ha7);
        sfr_write(8'hc5, 8'h12);
        sfr_read(8'hc5, 8'h92);
        expect_snap(1, 8'h08);
        for (i = 0; i < 8; i++) begin
            pow_write(8'(i));
            ratio(0, 10000);
            expect_snap(2, 8'(1 << i));
            ratio(1, 2000);
            expect_snap(2, 8'h05);
        end
        pow_write(8'h42);
        ratio(1, 2000);
        expect_snap(2, 8'h00);
        pow_write(8'h02);
        for (i = 0; i < 60000 && pll_locked !== 1'b1; i++) @(posedge mclk);
        meas = {7'h00, pll_locked};
        expect_snap(2, 8'h01);
        @(posedge mclk);
        xtal_run <= 1'b0;
        for (i = 0; i < 12000 && lock_loss_fault_flag !== 1'b1; i++) @(posedge mclk);
        n = 0;
        while (core_reset === 1'b1 && n < 100) begin
            n++;
            @(posedge mclk);
        end
        meas = 8'(n);
        expect_snap(2, 8'h10);
        expect_snap(1, 8'h02);
        sfr_write(8'hd8, 8'h7f);
        expect_snap(1, 8'h02);
        sfr_write(8'hd8, 8'h80);
        expect_snap(1, 8'h00);
        xtal_run <= 1'b1;
        close_out();
    end
endmodule : tb_top
`default_nettype wire
